//--- include/pwm_pkg.sv
// constants and carrier types for the pulse-width generator
package pwm_pkg;

  // clock
  localparam int CLK_MHZ = 100;
  localparam int CLK_NS = 10;

  // oscillator: 100 kHz nominal, +/-4 kHz jitter over 4 ms
  localparam int OSC_NOM_KHZ = 100;
  localparam int OSC_JIT_KHZ = 4;
  localparam int JIT_PERIOD_MS = 4;
  localparam int PERIOD_NOM = CLK_MHZ * 1000 / OSC_NOM_KHZ;
  localparam int PERIOD_MIN = CLK_MHZ * 1000 / (OSC_NOM_KHZ + OSC_JIT_KHZ);
  localparam int PERIOD_MAX = CLK_MHZ * 1000 / (OSC_NOM_KHZ - OSC_JIT_KHZ);
  localparam int JIT_HALF_CYC = JIT_PERIOD_MS * 1000 * CLK_MHZ / 2;
  localparam int JIT_SPAN = PERIOD_MAX - PERIOD_MIN;
  localparam int JIT_STEP_CYC = JIT_HALF_CYC / JIT_SPAN;

  // duty cap 0.75 as a ratio
  localparam int MAX_DUTY_NUM = 3;
  localparam int MAX_DUTY_DEN = 4;

  // leading-edge blanking, rounded up
  localparam int LEB_NORM_NS = 220;
  localparam int LEB_BURST_NS = 180;
  localparam int LEB_NORM_CYC = (LEB_NORM_NS + CLK_NS - 1) / CLK_NS;
  localparam int LEB_BURST_CYC = (LEB_BURST_NS + CLK_NS - 1) / CLK_NS;

  // long timers
  localparam int SOFT_START_MS = 10;
  localparam int BLANK_MS = 20;
  localparam int SPIKE_MS = 30;
  localparam int MS_CYC = CLK_MHZ * 1000;
  localparam int SOFT_START_CYC = SOFT_START_MS * MS_CYC;
  localparam int BLANK_CYC = BLANK_MS * MS_CYC;
  localparam int SPIKE_CYC = SPIKE_MS * MS_CYC;

  // extension counter
  localparam int EXT_COUNT = 256;
  localparam int TW = 24;
  localparam int PW = 12;

  // synchronised comparator events
  typedef struct packed {
    logic reg_cmp;
    logic soft_cmp;
    logic peak_cmp;
    logic burst_cmp;
    logic fb_burst_low;
    logic overload;
    logic blank_upper;
    logic blank_lower;
  } cmp_in_type;

  // blanking pin drive
  typedef struct packed {
    logic charge;
    logic discharge;
  } blank_drv_type;

  typedef enum logic [1:0] {
    OL_IDLE = 2'b00,
    OL_BASE = 2'b01,
    OL_EXT = 2'b11,
    OL_SPIKE = 2'b10
  } ol_state_type;

endpackage

//--- design/jitter_osc.sv
// jittered oscillator with duty-cycle cap
`timescale 1ns/1ps
`default_nettype none
module jitter_osc
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic jitter_en_i,
  // outputs
  output logic cycle_start_o,
  output logic max_on_o
);
  import pwm_pkg::*;

  logic [pwm_pkg::PW-1:0] cnt_q;
  logic [pwm_pkg::PW-1:0] period_q;
  logic [pwm_pkg::PW-1:0] on_lim_q;
  logic [pwm_pkg::TW-1:0] step_q;
  logic up_q;
  logic bump_q;
  logic [pwm_pkg::PW-1:0] period_d;
  logic wrap;

  assign wrap = (cnt_q >= period_q - 1'b1);

  // ------------------------------------------------------------
  // period counter
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      cycle_start_o <= 1'b0;
      max_on_o <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      cycle_start_o <= wrap;
      // cap on-time at 3/4 of the period
      max_on_o <= wrap || (cnt_q + 1'b1 < on_lim_q);
    end
  end

  // ------------------------------------------------------------
  // triangular period sweep
  // ------------------------------------------------------------
  // sweep steps only change the period at a wrap so each cycle stays whole; jitter off forces nominal at once
  always_comb
  begin
    period_d = period_q;
    if (bump_q && up_q && period_q < PW'(PERIOD_MAX))
      period_d = period_q + 1'b1;
    else if (bump_q && !up_q && period_q > PW'(PERIOD_MIN))
      period_d = period_q - 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      period_q <= PW'(PERIOD_NOM);
      on_lim_q <= PW'(PERIOD_NOM * MAX_DUTY_NUM / MAX_DUTY_DEN);
      step_q <= '0;
      up_q <= 1'b1;
      bump_q <= 1'b0;
    end
    else if (!jitter_en_i)
    begin
      period_q <= PW'(PERIOD_NOM);
      on_lim_q <= PW'(PERIOD_NOM * MAX_DUTY_NUM / MAX_DUTY_DEN);
      step_q <= '0;
      bump_q <= 1'b0;
    end
    else
    begin
      step_q <= (step_q >= TW'(JIT_STEP_CYC - 1)) ? '0 : step_q + 1'b1;
      if (wrap)
      begin
        period_q <= period_d;
        // limit follows the period of the cycle that starts now
        on_lim_q <= PW'((32'(period_d) * MAX_DUTY_NUM) / MAX_DUTY_DEN);
        bump_q <= 1'b0;
        if (bump_q && up_q && period_q >= PW'(PERIOD_MAX))
          up_q <= 1'b0;
        else if (bump_q && !up_q && period_q <= PW'(PERIOD_MIN))
          up_q <= 1'b1;
      end
      if (step_q >= TW'(JIT_STEP_CYC - 1))
        bump_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- design/pwm_limit_blanking.sv
// current-mode pulse generator with limiting and overload blanking
// Behaviour
// - cycle pulses at 100 kHz, swept +/-4 kHz over a 4 ms period
// - jitter only after soft start ends; nominal rate before
// - on-time never exceeds 0.75 of the period
// - latch set by cycle pulse, cleared by first of three comparators
// - cleared latch turns gate drive off at once
// - gate held low while supply is under lockout
// - peak comparator above threshold clears latch immediately
// - sense ignored 220 ns after turn-on, 180 ns in burst
// - blanking gates peak, burst comparators and sense amplifier alike
// - burst comparator enabled only in burst, limiting peak current
// - threshold dynamic for steeper slope, normal and burst limits
// - burst or restart needs condition held for 20 ms
// - only overload blanking extendable, only with capacitor present
// - extended: charge to upper, discharge to lower, count uppers
// - extension output high after 256 charge cycles
// - base and extension high: 30 ms spike blank, then restart
// - soft start ends 10 ms after switch-on
// - burst entry needs feedback low full 20 ms, else restart count
`timescale 1ns/1ps
`default_nettype none
module pwm_limit_blanking
#(
  parameter int SOFT_START_CYC = pwm_pkg::SOFT_START_CYC,
  parameter int BLANK_CYC = pwm_pkg::BLANK_CYC,
  parameter int SPIKE_CYC = pwm_pkg::SPIKE_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // supply and option inputs
  input wire logic supply_ok_i,
  input wire logic ext_cap_present_i,
  // comparator events
  input wire pwm_pkg::cmp_in_type cmp_i,
  // gate and sense
  output logic gate_o,
  output logic sense_enable_o,
  // blanking pin switches
  output pwm_pkg::blank_drv_type blank_drv_o,
  // mode outputs
  output logic soft_start_o,
  output logic burst_o,
  output logic restart_o,
  output logic ext_done_o
);
  import pwm_pkg::*;

  logic cycle_start;
  logic max_on;
  logic jitter_en;
  logic [TW-1:0] ss_cnt_q;
  logic [TW-1:0] burst_cnt_q;
  logic [TW-1:0] ol_cnt_q;
  logic [8:0] ext_cnt_q;
  logic [5:0] leb_cnt_q;
  logic gate_latch_q;
  logic leb_active;
  logic peak_trip;
  logic burst_trip;
  logic clear_ev;
  logic [5:0] leb_len;
  ol_state_type ol_q;

  // ------------------------------------------------------------
  // oscillator
  // ------------------------------------------------------------
  assign jitter_en = ~soft_start_o;

  jitter_osc u_osc
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .jitter_en_i(jitter_en),
    .cycle_start_o(cycle_start),
    .max_on_o(max_on)
  );

  // ------------------------------------------------------------
  // soft start timer
  // ------------------------------------------------------------
  // restarts from zero on every lockout and every restart attempt
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ss_cnt_q <= '0;
      soft_start_o <= 1'b1;
    end
    else if (!supply_ok_i || restart_o)
    begin
      ss_cnt_q <= '0;
      soft_start_o <= 1'b1;
    end
    else if (ss_cnt_q < TW'(SOFT_START_CYC - 1))
    begin
      ss_cnt_q <= ss_cnt_q + 1'b1;
      soft_start_o <= 1'b1;
    end
    else
      soft_start_o <= 1'b0;
  end

  // ------------------------------------------------------------
  // leading-edge blanking and current limits
  // ------------------------------------------------------------
  assign leb_len = burst_o ? 6'(LEB_BURST_CYC) : 6'(LEB_NORM_CYC);
  // blanking starts with the set pulse itself
  assign leb_active = (leb_cnt_q != '0) || cycle_start;
  // comparators arrive with a slope-dependent threshold already applied
  assign peak_trip = cmp_i.peak_cmp && !leb_active;
  assign burst_trip = cmp_i.burst_cmp && burst_o && !leb_active;
  assign clear_ev = peak_trip || burst_trip || !max_on
    || (cmp_i.reg_cmp && !leb_active)
    || (cmp_i.soft_cmp && soft_start_o && !leb_active);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      leb_cnt_q <= '0;
    else if (cycle_start && supply_ok_i)
      leb_cnt_q <= leb_len;
    else if (leb_cnt_q != '0)
      leb_cnt_q <= leb_cnt_q - 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sense_enable_o <= 1'b0;
    else
      sense_enable_o <= gate_latch_q && !leb_active;
  end

  // ------------------------------------------------------------
  // gate latch
  // ------------------------------------------------------------
  // the latch register itself drives the pin, so clear shows at once
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      gate_latch_q <= 1'b0;
    else if (!supply_ok_i || restart_o)
      gate_latch_q <= 1'b0;
    else if (clear_ev)
      gate_latch_q <= 1'b0;
    else if (cycle_start)
      gate_latch_q <= 1'b1;
  end

  assign gate_o = gate_latch_q;

  // ------------------------------------------------------------
  // burst entry blanking
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      burst_cnt_q <= '0;
      burst_o <= 1'b0;
    end
    else if (!supply_ok_i)
    begin
      burst_cnt_q <= '0;
      burst_o <= 1'b0;
    end
    else if (burst_o)
      burst_cnt_q <= '0;
    else if (!cmp_i.fb_burst_low)
      burst_cnt_q <= '0;
    else if (burst_cnt_q >= TW'(BLANK_CYC - 1))
      burst_o <= 1'b1;
    else
      burst_cnt_q <= burst_cnt_q + 1'b1;
  end

  // ------------------------------------------------------------
  // overload blanking, extension and spike timers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ol_q <= OL_IDLE;
      ol_cnt_q <= '0;
      restart_o <= 1'b0;
    end
    else if (!cmp_i.overload || !supply_ok_i)
    begin
      ol_q <= OL_IDLE;
      ol_cnt_q <= '0;
      restart_o <= 1'b0;
    end
    else
    begin
      case (ol_q)
        OL_IDLE:
        begin
          ol_cnt_q <= '0;
          ol_q <= OL_BASE;
        end
        OL_BASE:
        begin
          ol_cnt_q <= ol_cnt_q + 1'b1;
          if (ol_cnt_q >= TW'(BLANK_CYC - 1))
          begin
            ol_cnt_q <= '0;
            ol_q <= ext_cap_present_i ? OL_EXT : OL_SPIKE;
          end
        end
        OL_EXT:
        begin
          if (ext_done_o)
            ol_q <= OL_SPIKE;
        end
        OL_SPIKE:
        begin
          if (ol_cnt_q >= TW'(SPIKE_CYC - 1))
            restart_o <= 1'b1;
          else
            ol_cnt_q <= ol_cnt_q + 1'b1;
        end
        default:
          ol_q <= OL_IDLE;
      endcase
    end
  end

  // charge/discharge sequencer on the blanking pin
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blank_drv_o <= '0;
      ext_cnt_q <= '0;
      ext_done_o <= 1'b0;
    end
    else if (ol_q != OL_EXT || !cmp_i.overload)
    begin
      blank_drv_o <= '0;
      if (ol_q != OL_SPIKE || !cmp_i.overload)
      begin
        ext_cnt_q <= '0;
        ext_done_o <= 1'b0;
      end
    end
    else if (ext_done_o)
      blank_drv_o <= '0;
    else if (blank_drv_o.charge && cmp_i.blank_upper)
    begin
      blank_drv_o <= '{charge: 1'b0, discharge: 1'b1};
      ext_cnt_q <= ext_cnt_q + 1'b1;
      ext_done_o <= (ext_cnt_q + 1'b1 >= 9'(EXT_COUNT));
    end
    else if (blank_drv_o.discharge && cmp_i.blank_lower)
      blank_drv_o <= '{charge: 1'b1, discharge: 1'b0};
    else if (!blank_drv_o.charge && !blank_drv_o.discharge)
      blank_drv_o <= '{charge: 1'b1, discharge: 1'b0};
  end
endmodule
`default_nettype wire

//--- dv/pwm_limit_blanking_props.sv
// port assertions for the pulse generator
`timescale 1ns/1ps
`default_nettype none
module pwm_limit_blanking_props
#(
  parameter int SOFT_START_CYC = 200,
  parameter int BLANK_CYC = 100,
  parameter int SPIKE_CYC = 150
)
(
  // clock and inputs
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic ext_cap_present_i,
  input wire pwm_pkg::cmp_in_type cmp_i,
  // outputs watched
  input wire logic gate_o,
  input wire logic sense_enable_o,
  input wire pwm_pkg::blank_drv_type blank_drv_o,
  input wire logic soft_start_o,
  input wire logic burst_o,
  input wire logic restart_o,
  input wire logic ext_done_o
);
  import pwm_pkg::*;
  logic [9:0] on_q;
  logic [31:0] ol_q;
  logic [31:0] fb_q;
  logic [8:0] up_q;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // run lengths; uppers seen as discharge starts
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      on_q <= 10'h000;
      ol_q <= 32'h0;
      fb_q <= 32'h0;
      up_q <= 9'h000;
    end
    else
    begin
      on_q <= gate_o ? on_q + 10'h001 : 10'h000;
      ol_q <= cmp_i.overload ? ol_q + 32'h1 : 32'h0;
      fb_q <= cmp_i.fb_burst_low ? fb_q + 32'h1 : 32'h0;
      up_q <= !cmp_i.overload ? 9'h000 : up_q + 9'($rose(blank_drv_o.discharge));
    end
  end
  a_lockout_gate_low: assert property (
    !supply_ok_i |=> !gate_o) else $error("gate on under lockout");
  a_peak_ends_on: assert property (
    gate_o && sense_enable_o && $past(sense_enable_o) && cmp_i.peak_cmp
    |=> !gate_o) else $error("peak did not end on-time");
  a_blank_early: assert property (
    gate_o && on_q < 10'h00F |-> !sense_enable_o) else $error("sense early");
  a_blank_ends: assert property (
    gate_o && on_q == 10'h01E |-> sense_enable_o) else $error("sense late");
  a_duty_cap: assert property (
    gate_o |-> on_q <= 10'h30E) else $error("on-time too long");
  a_drive_excl: assert property (
    !(blank_drv_o.charge && blank_drv_o.discharge)) else $error("both on");
  a_no_cap_idle: assert property (
    !ext_cap_present_i |-> blank_drv_o == 2'b00) else $error("pin driven");
  a_overload_clear: assert property (
    !cmp_i.overload |=> !restart_o && !ext_done_o && blank_drv_o == 2'b00)
    else $error("overload state kept");
  a_restart_wait: assert property (
    $rose(restart_o) |-> ol_q >= BLANK_CYC + SPIKE_CYC - 4)
    else $error("restart early");
  a_ext_count: assert property (
    $rose(ext_done_o) |-> up_q >= 9'h0FF && up_q <= 9'h100)
    else $error("bad extension count");
  a_burst_entry: assert property (
    $rose(burst_o) |-> fb_q >= BLANK_CYC - 2) else $error("burst early");
endmodule
bind pwm_limit_blanking pwm_limit_blanking_props #(
  .SOFT_START_CYC(SOFT_START_CYC), .BLANK_CYC(BLANK_CYC),
  .SPIKE_CYC(SPIKE_CYC)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .supply_ok_i(supply_ok_i), .ext_cap_present_i(ext_cap_present_i),
  .cmp_i(cmp_i), .gate_o(gate_o), .sense_enable_o(sense_enable_o),
  .blank_drv_o(blank_drv_o), .soft_start_o(soft_start_o),
  .burst_o(burst_o), .restart_o(restart_o), .ext_done_o(ext_done_o));
`default_nettype wire

//--- dv/sense_partner.sv
// far-side model: current ramp and blanking capacitor
`timescale 1ns/1ps
`default_nettype none
module sense_partner
(
  // clock and device drive
  input wire logic clk_i,
  input wire logic gate_i,
  input wire pwm_pkg::blank_drv_type drv_i,
  // trip point in cycles, 0 never trips
  input wire logic [9:0] trip_i,
  // comparator levels
  output logic peak_o,
  output logic upper_o,
  output logic lower_o
);
  import pwm_pkg::*;
  logic [9:0] on_q = 10'h000;
  logic [3:0] cap_q = 4'h0;
  initial {peak_o, upper_o, lower_o} = 3'b001;
  // slow ramps so the extension takes many cycles
  always @(negedge clk_i)
  begin
    on_q <= gate_i ? on_q + 10'h001 : 10'h000;
    peak_o <= gate_i && trip_i != 10'h000 && on_q >= trip_i;
    if (drv_i.charge && cap_q != 4'hF)
      cap_q <= cap_q + 4'h1;
    else if (drv_i.discharge && cap_q != 4'h0)
      cap_q <= cap_q - 4'h1;
    upper_o <= cap_q >= 4'hC;
    lower_o <= cap_q <= 4'h3;
  end
endmodule
`default_nettype wire

//--- dv/pwm_limit_blanking_bench.sv
// self-checking bench for the pulse generator
`timescale 1ns/1ps
`default_nettype none
module pwm_limit_blanking_bench;
  import pwm_pkg::*;
  localparam int BLK = 100;
  localparam int SPK = 150;
  // soft start longer than one period so a soft clear can be seen
  localparam int SST = 1500;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_ok_i = 1'b0;
  logic ext_cap_present_i = 1'b0;
  logic regc = 1'b0;
  logic burstc = 1'b0;
  logic softc = 1'b0;
  logic fbl = 1'b0;
  logic ovl = 1'b0;
  logic peak, upper, lower;
  logic [9:0] trip = 10'h000;
  logic gate_o, sense_enable_o, soft_start_o, burst_o, restart_o, ext_done_o;
  blank_drv_type blank_drv_o;
  logic [15:0] exp_q[$];
  event chk_ev;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int t;
  logic [31:0] seed = 32'h2DE109FD;
  wire cmp_in_type cmp_i = {regc, softc, peak, burstc, fbl, ovl, upper, lower};
  wire [7:0] obs = {sense_enable_o, gate_o, soft_start_o, burst_o, restart_o,
    ext_done_o, blank_drv_o};

  always #5 clk_i = ~clk_i;

  pwm_limit_blanking #(.SOFT_START_CYC(SST), .BLANK_CYC(BLK),
    .SPIKE_CYC(SPK)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .supply_ok_i(supply_ok_i), .ext_cap_present_i(ext_cap_present_i),
    .cmp_i(cmp_i), .gate_o(gate_o), .sense_enable_o(sense_enable_o),
    .blank_drv_o(blank_drv_o), .soft_start_o(soft_start_o),
    .burst_o(burst_o), .restart_o(restart_o), .ext_done_o(ext_done_o));
  sense_partner u_far (.clk_i(clk_i), .gate_i(gate_o), .drv_i(blank_drv_o),
    .trip_i(trip), .peak_o(peak), .upper_o(upper), .lower_o(lower));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // note: mask then value, compared by the watcher
  task automatic expect_o(input logic [7:0] m, input logic [7:0] v);
    exp_q.push_back({m, v});
    -> chk_ev;
  endtask
  task automatic wait_gate(input logic v);
    int k;
    k = 0;
    while (gate_o !== v && k < 1200)
    begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic on_test(input int tr, input int hi, input int lo);
    trip = tr[9:0];
    wait_gate(1'b0);
    wait_gate(1'b1);
    cyc_n(hi);
    expect_o(8'h40, 8'h40);
    cyc_n(lo - hi);
    expect_o(8'h40, 8'h00);
    trip = 10'h000;
  endtask
  task automatic final_report();
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(chk_ev)
  begin
    while (exp_q.size() > 0)
    begin
      num_checks++;
      if (((obs ^ exp_q[0][7:0]) & exp_q[0][15:8]) !== 8'h00)
      begin
        err_count++;
        $display("ERROR t=%0t got %h exp %h", $time, obs, exp_q[0][7:0]);
      end
      void'(exp_q.pop_front());
    end
  end

  // hang guard, about two and a half times the expected run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    cyc_n(8);
    rst_i = 1'b0;
    cyc_n(1);
    expect_o(8'hFF, 8'h20);
    supply_ok_i = 1'b1;
    wait_gate(1'b1);
    cyc_n(700);
    expect_o(8'h60, 8'h40);
    cyc_n(258);
    expect_o(8'h40, 8'h00);
    cyc_n(87);
    expect_o(8'h40, 8'h40);
    on_test(5, 16, 30);
    repeat (3)
    begin
      t = 40 + int'(xs() % 400);
      on_test(t, t - 3, t + 4);
    end
    wait_gate(1'b0);
    wait_gate(1'b1);
    cyc_n(40);
    expect_o(8'hC0, 8'hC0);
    regc = 1'b1;
    cyc_n(3);
    expect_o(8'h40, 8'h00);
    regc = 1'b0;
    fbl = 1'b1;
    cyc_n(BLK + 5);
    expect_o(8'h10, 8'h10);
    burstc = 1'b1;
    on_test(0, 12, 22);
    burstc = 1'b0;
    fbl = 1'b0;
    supply_ok_i = 1'b0;
    cyc_n(3);
    expect_o(8'h50, 8'h00);
    supply_ok_i = 1'b1;
    softc = 1'b1;
    wait_gate(1'b1);
    cyc_n(30);
    expect_o(8'h60, 8'h20);
    softc = 1'b0;
    ovl = 1'b1;
    cyc_n(80);
    ovl = 1'b0;
    cyc_n(2);
    ovl = 1'b1;
    cyc_n(BLK + SPK - 20);
    expect_o(8'h0B, 8'h00);
    cyc_n(40);
    expect_o(8'h0F, 8'h08);
    ovl = 1'b0;
    cyc_n(3);
    expect_o(8'h0F, 8'h00);
    ext_cap_present_i = 1'b1;
    ovl = 1'b1;
    cyc_n(BLK + 5);
    expect_o(8'h0B, 8'h02);
    t = 0;
    while (ext_done_o !== 1'b1 && t < 9000)
    begin
      cyc_n(1);
      t++;
    end
    cyc_n(2);
    expect_o(8'h0F, 8'h04);
    cyc_n(SPK + 5);
    expect_o(8'h0F, 8'h0C);
    ovl = 1'b0;
    cyc_n(3);
    final_report();
  end
endmodule
`default_nettype wire
